/* common/rtc_status_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef RTC_STATUS_DEFS_SVH
`define RTC_STATUS_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define IDX_HALT        8'h01
`define IDX_CENTURY     8'h05
`define IDX_CALIB       8'h08
`define IDX_WDOG        8'h09
`define IDX_ALARM1      8'h0a
`define IDX_FLAGS       8'h0f
`define IDX_SQUARE      8'h13

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_HALT        7
`define BIT_CENT_LO     6
`define BIT_PIN_LEVEL   7
`define BIT_FREQ_TEST   6
`define BIT_OSC_FAIL_IRQ_ENABLE        7
`define BIT_A1IE        7
`define BIT_SQUARE_OUTPUT_ENABLE        6
`define BIT_ABE         5
`define BIT_BATT_WEAK   4
`define BIT_OSC_STOP    2
`define BIT_RATE_LO     4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_OSC_STOP    1'b1
`define RST_BATT_WEAK   1'b0
`define RST_RATE        4'h0
`define RST_CENTURY     2'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   100
`define LOAD_SETTLE_NS  1000
`define KICK_TIME_NS    100000
`define LOAD_CYCLES     ((`LOAD_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define KICK_CYCLES     (`KICK_TIME_NS / `CLK_PERIOD_NS)
`define FT_TAP          5

`endif

/* common/rtc_status_pkg.sv */
// types shared by the status and output logic
package rtc_status_pkg;

  typedef enum logic [2:0] {
    CHK_IDLE    = 3'b001,
    CHK_LOAD    = 3'b010,
    CHK_COMPARE = 3'b100
  } batt_check_state_t;

  typedef struct packed {
    logic pin_level;
    logic freq_test_enable;
    logic osc_fail_irq_enable;
    logic alarm1_irq_enable;
    logic backup_irq_enable;
  } pin_cfg_t;

endpackage

/* hdl/rtc_status_out.sv */
// status flags, square wave and shared open-drain pin of the rtc
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps

module rtc_status_out
  import rtc_status_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_clk,
  input  wire logic        main_supply_ok,
  input  wire logic        battery_below_cmp,
  input  wire logic        osc_stop_detect,
  input  wire logic        midnight_rollover,
  input  wire logic        year_rollover,
  input  wire logic [7:0]  year_bcd,
  input  wire logic        timer_irq_req,
  input  wire logic        timer_irq_enable,
  input  wire logic        watchdog_irq_req,
  input  wire logic        watchdog_running,
  input  wire logic        alarm1_flag,
  output logic             leap_day_en,
  output logic             battery_load,
  output logic             osc_enable,
  output logic             osc_kick_drive,
  output logic             square_wave_pin,
  output logic             shared_irq_pin_out,
  output logic             shared_irq_pin_oe_n
);

  `include "rtc_status_defs.svh"

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] osc_sync;
  logic [1:0] main_sync;
  logic [1:0] batt_sync;
  logic [1:0] stop_sync;
  logic       osc_prev;
  logic       main_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_sync  <= 2'h0;
      main_sync <= 2'h0;
      batt_sync <= 2'h0;
      stop_sync <= 2'h0;
      osc_prev  <= 1'b0;
      main_prev <= 1'b0;
    end
    else
    begin
      osc_sync  <= {osc_sync[0], osc_clk};
      main_sync <= {main_sync[0], main_supply_ok};
      batt_sync <= {batt_sync[0], battery_below_cmp};
      stop_sync <= {stop_sync[0], osc_stop_detect};
      osc_prev  <= osc_sync[1];
      main_prev <= main_sync[1];
    end
  end

  logic main_ok;
  logic osc_rise;
  logic power_up;
  assign main_ok  = main_sync[1];
  assign osc_rise = osc_sync[1] & ~osc_prev;
  assign power_up = main_ok & ~main_prev;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  pin_cfg_t   cfg;
  logic       square_output_enable;
  logic [3:0] square_rate_sel;
  logic       osc_halt_bit;
  logic [1:0] century_count;
  logic       osc_stopped_flag;
  logic       battery_weak_flag;

  function automatic logic hit(input logic [11:0] addr, input logic [7:0] idx);
    hit = (addr[11:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
  endfunction

  logic setup;
  logic access_wr;
  logic mapped;
  assign setup     = psel & ~penable;
  assign access_wr = psel & penable & pwrite;
  assign mapped    = hit(paddr, `IDX_HALT) | hit(paddr, `IDX_CENTURY)
                   | hit(paddr, `IDX_CALIB) | hit(paddr, `IDX_WDOG)
                   | hit(paddr, `IDX_ALARM1) | hit(paddr, `IDX_FLAGS)
                   | hit(paddr, `IDX_SQUARE);

  // zero wait states: read data is captured in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg                  <= '0;
      square_output_enable <= 1'b0;
      square_rate_sel      <= `RST_RATE;
      osc_halt_bit         <= 1'b0;
    end
    else if (access_wr)
    begin
      if (hit(paddr, `IDX_CALIB))
      begin
        cfg.pin_level        <= pwdata[`BIT_PIN_LEVEL];
        cfg.freq_test_enable <= pwdata[`BIT_FREQ_TEST];
      end
      if (hit(paddr, `IDX_WDOG))
        cfg.osc_fail_irq_enable <= pwdata[`BIT_OSC_FAIL_IRQ_ENABLE];
      if (hit(paddr, `IDX_ALARM1))
      begin
        cfg.alarm1_irq_enable <= pwdata[`BIT_A1IE];
        cfg.backup_irq_enable <= pwdata[`BIT_ABE];
        square_output_enable  <= pwdata[`BIT_SQUARE_OUTPUT_ENABLE];
      end
      if (hit(paddr, `IDX_SQUARE))
        square_rate_sel <= pwdata[`BIT_RATE_LO +: 4];
      if (hit(paddr, `IDX_HALT))
        osc_halt_bit <= pwdata[`BIT_HALT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (setup)
    begin
      prdata <= 32'h0;
      if (hit(paddr, `IDX_HALT))
        prdata[`BIT_HALT] <= osc_halt_bit;
      if (hit(paddr, `IDX_CENTURY))
        prdata[`BIT_CENT_LO +: 2] <= century_count;
      if (hit(paddr, `IDX_CALIB))
      begin
        prdata[`BIT_PIN_LEVEL] <= cfg.pin_level;
        prdata[`BIT_FREQ_TEST] <= cfg.freq_test_enable;
      end
      if (hit(paddr, `IDX_WDOG))
        prdata[`BIT_OSC_FAIL_IRQ_ENABLE] <= cfg.osc_fail_irq_enable;
      if (hit(paddr, `IDX_ALARM1))
      begin
        prdata[`BIT_A1IE] <= cfg.alarm1_irq_enable;
        prdata[`BIT_SQUARE_OUTPUT_ENABLE] <= square_output_enable;
        prdata[`BIT_ABE]  <= cfg.backup_irq_enable;
      end
      if (hit(paddr, `IDX_FLAGS))
      begin
        prdata[`BIT_BATT_WEAK] <= battery_weak_flag;
        prdata[`BIT_OSC_STOP]  <= osc_stopped_flag;
      end
      if (hit(paddr, `IDX_SQUARE))
        prdata[`BIT_RATE_LO +: 4] <= square_rate_sel;
    end
  end

  // ----------------------------------------------------------------
  // century counter and leap day
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      century_count <= `RST_CENTURY;
    else if (year_rollover)
      century_count <= century_count + 2'h1;
    else if (access_wr && hit(paddr, `IDX_CENTURY))
      century_count <= pwdata[`BIT_CENT_LO +: 2];
  end

  // bcd year divisible by four; the 100/400 exceptions are left to software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      leap_day_en <= 1'b0;
    else
      leap_day_en <= year_bcd[4] ? (year_bcd[3:0] == 4'h2 || year_bcd[3:0] == 4'h6)
                                 : (year_bcd[3:0] == 4'h0 || year_bcd[3:0] == 4'h4
                                    || year_bcd[3:0] == 4'h8);
  end

  // ----------------------------------------------------------------
  // battery check
  // ----------------------------------------------------------------
  batt_check_state_t chk_state;
  logic [7:0]        load_cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chk_state         <= CHK_IDLE;
      load_cnt          <= 8'h0;
      battery_load      <= 1'b0;
      battery_weak_flag <= `RST_BATT_WEAK;
    end
    else
    begin
      case (chk_state)
        CHK_IDLE:
        begin
          if (power_up)
            battery_weak_flag <= batt_sync[1];
          else if (midnight_rollover && main_ok)
          begin
            chk_state    <= CHK_LOAD;
            battery_load <= 1'b1;
            load_cnt     <= 8'(`LOAD_CYCLES);
          end
        end
        CHK_LOAD:
        begin
          if (!main_ok)
          begin
            chk_state    <= CHK_IDLE;
            battery_load <= 1'b0;
          end
          else if (load_cnt == 8'h1)
            chk_state <= CHK_COMPARE;
          else
            load_cnt <= load_cnt - 8'h1;
        end
        CHK_COMPARE:
        begin
          battery_weak_flag <= batt_sync[1];
          battery_load      <= 1'b0;
          chk_state         <= CHK_IDLE;
        end
        default:
        begin
          chk_state    <= CHK_IDLE;
          battery_load <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // oscillator stop flag and kick-start
  // ----------------------------------------------------------------
  logic        halt_prev;
  logic [13:0] kick_cnt;
  logic        flags_clear;
  assign flags_clear = access_wr & hit(paddr, `IDX_FLAGS) & ~pwdata[`BIT_OSC_STOP];

  // set beats clear; detection runs in backup mode too
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_stopped_flag <= `RST_OSC_STOP;
    else if (stop_sync[1] || osc_halt_bit)
      osc_stopped_flag <= 1'b1;
    else if (flags_clear)
      osc_stopped_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      halt_prev      <= 1'b0;
      kick_cnt       <= 14'h0;
      osc_kick_drive <= 1'b0;
      osc_enable     <= 1'b1;
    end
    else
    begin
      halt_prev  <= osc_halt_bit;
      osc_enable <= ~osc_halt_bit;
      if (halt_prev && !osc_halt_bit)
      begin
        kick_cnt       <= 14'(`KICK_CYCLES);
        osc_kick_drive <= 1'b1;
      end
      else if (kick_cnt != 14'h0)
      begin
        kick_cnt       <= kick_cnt - 14'h1;
        osc_kick_drive <= (kick_cnt != 14'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // square wave divider
  // ----------------------------------------------------------------
  logic [14:0] osc_div;
  logic        square_sel;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      osc_div <= 15'h0;
    else if (osc_rise)
      osc_div <= osc_div + 15'h1;
  end

  always_comb
  begin
    if (square_rate_sel == 4'h0)
      square_sel = 1'b0;
    else if (square_rate_sel == 4'h1)
      square_sel = osc_sync[1];
    else
      square_sel = osc_div[square_rate_sel - 4'h1];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      square_wave_pin <= 1'b0;
    else
      square_wave_pin <= square_sel & square_output_enable & main_ok;
  end

  // ----------------------------------------------------------------
  // shared open-drain pin
  // ----------------------------------------------------------------
  logic osc_irq;
  logic alarm_irq;
  logic irq_main;
  logic irq_backup;
  logic any_en_main;
  logic any_en_backup;
  logic pin_level_next;

  assign osc_irq       = osc_stopped_flag & cfg.osc_fail_irq_enable;
  assign alarm_irq     = alarm1_flag & cfg.alarm1_irq_enable;
  assign irq_main      = timer_irq_req | osc_irq | alarm_irq | watchdog_irq_req;
  assign irq_backup    = osc_irq | alarm_irq;
  assign any_en_main   = cfg.alarm1_irq_enable | cfg.osc_fail_irq_enable
                       | timer_irq_enable | watchdog_running;
  assign any_en_backup = cfg.alarm1_irq_enable | cfg.osc_fail_irq_enable;

  always_comb
  begin
    if (main_ok)
    begin
      if (!cfg.pin_level && !cfg.freq_test_enable)
        pin_level_next = 1'b0;
      else if (cfg.freq_test_enable && (!cfg.pin_level || !any_en_main))
        pin_level_next = osc_div[`FT_TAP];
      else if (any_en_main)
        pin_level_next = ~irq_main;
      else
        pin_level_next = 1'b1;
    end
    else
    begin
      // frequency test has no meaning without main power
      if (!cfg.backup_irq_enable)
        pin_level_next = 1'b1;
      else if (!cfg.pin_level)
        pin_level_next = 1'b0;
      else if (any_en_backup)
        pin_level_next = ~irq_backup;
      else
        pin_level_next = 1'b1;
    end
  end

  // the pin only ever pulls low; high comes from the external pull-up
  assign shared_irq_pin_out = 1'b0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shared_irq_pin_oe_n <= 1'b1;
    else
      shared_irq_pin_oe_n <= pin_level_next;
  end

endmodule // rtc_status_out

/* sim/rtc_osc_model.sv */
// free-running model of the timekeeping crystal
`timescale 1ns/1ps

module rtc_osc_model (
  output logic osc_clk
);
  // crystals run free, so no framing; odd start keeps phase apart from pclk
  initial
  begin
    osc_clk = 1'b0;
    #37;
    forever #400 osc_clk = ~osc_clk;
  end
endmodule // rtc_osc_model

/* sim/rtc_status_monitor.sv */
// concurrent checks on the ports of the status and output block
`timescale 1ns/1ps
`include "rtc_status_defs.svh"

module rtc_status_monitor (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       main_supply_ok,
  input wire logic       midnight_rollover,
  input wire logic [7:0] year_bcd,
  input wire logic       leap_day_en,
  input wire logic       battery_load,
  input wire logic       osc_enable,
  input wire logic       osc_kick_drive,
  input wire logic       square_wave_pin,
  input wire logic       shared_irq_pin_out
);
  // kick length is far beyond a repetition count, so count it here
  int kick_cnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      kick_cnt <= 0;
    else
      kick_cnt <= osc_kick_drive ? kick_cnt + 1 : 0;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_backup;
    !main_supply_ok [*3];
  endsequence
  sequence s_load_run;
    battery_load [*8] ##1 battery_load [*3] ##1 !battery_load;
  endsequence

  a_pin_open_drain:
    assert property (shared_irq_pin_out == 1'b0) else $error("shared pin driven high");
  a_load_from_pulse:
    assert property ($rose(battery_load) |-> $past(midnight_rollover))
      else $error("load without midnight pulse");
  a_load_length:
    assert property ($rose(battery_load) |-> s_load_run) else $error("load length wrong");
  a_no_load_backup:
    assert property (s_backup ##0 midnight_rollover |=> !battery_load)
      else $error("check ran in backup");
  a_square_off_backup:
    assert property (!main_supply_ok [*4] |-> !square_wave_pin)
      else $error("square wave in backup");
  a_kick_on_start:
    assert property ($rose(osc_enable) |-> ##[0:1] osc_kick_drive)
      else $error("no kick on restart");
  a_kick_length:
    assert property ($fell(osc_kick_drive) |-> kick_cnt == `KICK_CYCLES)
      else $error("kick length wrong");
  a_leap_day:
    assert property ($past(presetn) |->
      leap_day_en == ($past(year_bcd[1:0]) == {$past(year_bcd[4]), 1'b0}))
      else $error("leap day wrong");
endmodule // rtc_status_monitor

bind rtc_status_out rtc_status_monitor u_mon (.pclk, .presetn, .main_supply_ok,
  .midnight_rollover, .year_bcd, .leap_day_en, .battery_load, .osc_enable,
  .osc_kick_drive, .square_wave_pin, .shared_irq_pin_out);

/* sim/rtc_status_out_tb.sv */
// self-checking bench for the status and output block
`timescale 1ns/1ps
`include "rtc_status_defs.svh"

module rtc_status_out_tb
  import rtc_status_pkg::*;
;
  localparam logic [11:0] ad_ht  = 12'(`IDX_HALT) << 2;
  localparam logic [11:0] ad_ce  = 12'(`IDX_CENTURY) << 2;
  localparam logic [11:0] ad_cal = 12'(`IDX_CALIB) << 2;
  localparam logic [11:0] ad_wd  = 12'(`IDX_WDOG) << 2;
  localparam logic [11:0] ad_al  = 12'(`IDX_ALARM1) << 2;
  localparam logic [11:0] ad_fl  = 12'(`IDX_FLAGS) << 2;
  localparam logic [11:0] ad_sq  = 12'(`IDX_SQUARE) << 2;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  year_bcd;
  logic        osc_clk, main_supply_ok, battery_below_cmp, osc_stop_detect;
  logic        midnight_rollover, year_rollover, timer_irq_req, timer_irq_enable;
  logic        watchdog_irq_req, watchdog_running, alarm1_flag, leap_day_en;
  logic        battery_load, osc_enable, osc_kick_drive, square_wave_pin;
  logic        shared_irq_pin_out, shared_irq_pin_oe_n;
  int          failures, checks_done, c, p;

  always #50 pclk = ~pclk;

  rtc_osc_model osc (.osc_clk);
  rtc_status_out DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .osc_clk, .main_supply_ok, .battery_below_cmp,
    .osc_stop_detect, .midnight_rollover, .year_rollover, .year_bcd, .timer_irq_req,
    .timer_irq_enable, .watchdog_irq_req, .watchdog_running, .alarm1_flag,
    .leap_day_en, .battery_load, .osc_enable, .osc_kick_drive, .square_wave_pin,
    .shared_irq_pin_out, .shared_irq_pin_oe_n);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // idle cycles after each transfer let register effects reach the pins
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      finish_test;
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    cyc(4);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(r, {24'h0, x});
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: return square_wave_pin;
      1: return shared_irq_pin_oe_n;
      2: return battery_load;
      default: return osc_kick_drive;
    endcase
  endfunction

  task automatic hi_count(input int w, input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge pclk);
      k += $isunknown(sel(w)) ? 1000 : int'(sel(w));
    end
  endtask

  // cycles between two rises; zero if the wave never comes
  task automatic meas(input int w, output int q);
    int k;
    logic o;
    k = -1;
    o = 1'b1;
    q = 0;
    for (int n = 0; n < 3000 && q == 0; n++)
    begin
      @(posedge pclk);
      if (k >= 0)
        k++;
      if (sel(w) === 1'b1 && !o)
      begin
        if (k > 0)
          q = k;
        k = 0;
      end
      o = sel(w) === 1'b1;
    end
  endtask

  task automatic pin(input int x);
    cyc(3);
    hi_count(1, 20, c);
    chk(c, x);
  endtask

  task automatic stop_pulse;
    osc_stop_detect <= 1'b1;
    cyc(6);
    osc_stop_detect <= 1'b0;
    cyc(4);
  endtask

  task automatic mid_pulse;
    midnight_rollover <= 1'b1;
    cyc(1);
    midnight_rollover <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, year_bcd} = '0;
    {midnight_rollover, year_rollover, osc_stop_detect, timer_irq_req} = '0;
    {timer_irq_enable, watchdog_irq_req, watchdog_running, alarm1_flag} = '0;
    {main_supply_ok, battery_below_cmp} = 2'b11;
    {failures, checks_done} = '0;
    cyc(2);
    presetn <= 1'b1;
    cyc(8);
    rd(ad_fl, 8'h14);
    rd(ad_sq, 8'h00);
    apb(1'b0, 12'h008, 8'h00);
    chk(e, 1'b1);
    wr(ad_fl, 8'h00);
    rd(ad_fl, 8'h10);
    rd(ad_fl, 8'h10);
    battery_below_cmp <= 1'b0;
    cyc(6);
    rd(ad_fl, 8'h10);
    mid_pulse;
    hi_count(2, 20, c);
    chk(c, `LOAD_CYCLES + 1);
    rd(ad_fl, 8'h00);
    {battery_below_cmp, main_supply_ok} <= 2'b10;
    cyc(6);
    mid_pulse;
    hi_count(2, 20, c);
    chk(c, 0);
    stop_pulse;
    rd(ad_fl, 8'h04);
    main_supply_ok <= 1'b1;
    hi_count(2, 10, c);
    chk(c, 0);
    rd(ad_fl, 8'h14);
    wr(ad_fl, 8'h00);
    wr(ad_al, 8'h40);
    for (int k = 1; k < 7; k++)
    begin
      wr(ad_sq, 8'(k << 4));
      meas(0, p);
      chk(p, k == 1 ? 8 : 8 << k);
    end
    wr(ad_sq, 8'h00);
    hi_count(0, 40, c);
    chk(c, 0);
    wr(ad_sq, 8'h10);
    wr(ad_al, 8'h00);
    hi_count(0, 40, c);
    chk(c, 0);
    wr(ad_al, 8'h40);
    main_supply_ok <= 1'b0;
    cyc(4);
    hi_count(0, 40, c);
    chk(c, 0);
    main_supply_ok <= 1'b1;
    wr(ad_al, 8'h00);
    wr(ad_cal, 8'h00);
    pin(0);
    wr(ad_cal, 8'h80);
    pin(20);
    for (int k = 0; k < 2; k++)
    begin
      wr(ad_cal, k ? 8'hc0 : 8'h40);
      meas(1, p);
      chk(p, 512);
    end
    wr(ad_cal, 8'h80);
    wr(ad_wd, 8'h80);
    pin(20);
    stop_pulse;
    pin(0);
    wr(ad_wd, 8'h00);
    pin(20);
    wr(ad_wd, 8'h80);
    pin(0);
    wr(ad_fl, 8'h00);
    pin(20);
    wr(ad_wd, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      {timer_irq_enable, timer_irq_req} <= {2{k == 0}};
      {watchdog_running, watchdog_irq_req} <= {2{k == 1}};
      alarm1_flag <= k == 2;
      wr(ad_al, k == 2 ? 8'h80 : 8'h00);
      pin(0);
    end
    main_supply_ok <= 1'b0;
    wr(ad_al, 8'h80);
    pin(20);
    wr(ad_al, 8'ha0);
    pin(0);
    {alarm1_flag, timer_irq_enable, timer_irq_req, watchdog_running, watchdog_irq_req} <= 5'h0f;
    pin(20);
    wr(ad_cal, 8'h00);
    pin(0);
    wr(ad_cal, 8'h80);
    wr(ad_al, 8'h20);
    wr(ad_wd, 8'h80);
    pin(20);
    stop_pulse;
    pin(0);
    main_supply_ok <= 1'b1;
    wr(ad_ce, 8'h80);
    for (int k = 3; k < 6; k++)
    begin
      year_rollover <= 1'b1;
      cyc(1);
      year_rollover <= 1'b0;
      cyc(2);
      rd(ad_ce, 8'((k % 4) << 6));
    end
    for (int y = 0; y < 100; y++)
    begin
      year_bcd <= 8'((y / 10) * 16 + y % 10);
      cyc(3);
      chk(leap_day_en, y % 4 == 0);
    end
    rd(ad_fl, 8'h14);
    wr(ad_ht, 8'h80);
    chk(osc_enable, 1'b0);
    rd(ad_fl, 8'h14);
    fork
      hi_count(3, 1100, c);
      wr(ad_ht, 8'h00);
    join
    chk(c, `KICK_CYCLES);
    chk(osc_enable, 1'b1);
    finish_test;
  end
endmodule // rtc_status_out_tb
